/* verilog/tx_fifo_packing_and_status.sv */
`include "tx_cfg.svh"
module tx_fifo_packing_and_status import tx_pkg::*; #(
    parameter int DAW = 6,  // log2 of data fifo depth
    parameter int SAW = 3   // log2 of status fifo depth
) (
    input logic pclk,                    // system clock
    input logic presetn,                 // async reset, active low
    input logic [7:0] paddr,             // apb byte address
    input logic psel,                    // apb select
    input logic penable,                 // apb access phase
    input logic pwrite,                  // apb direction
    input logic [31:0] pwdata,           // apb write data
    output logic [31:0] prdata,          // apb read data
    output logic pready,                 // apb ready
    output logic pslverr,                // apb error, unmapped address
    input logic mac_ready,               // mac takes the data word
    output logic mac_valid,              // data word on offer
    output logic [31:0] mac_data,        // payload dword
    output logic mac_last,               // last dword of the packet
    input logic mac_tx_done,             // packet finished, one-cycle pulse
    input tx_result_t mac_result,        // outcome valid with mac_tx_done
    output logic tx_suspended,           // next packet held for status room
    output logic transmitter_error_flag  // sticky error, write one to clear
);
    fifo_if #(.W(34), .AW(DAW)) dif();
    fifo_if #(.W(32), .AW(SAW)) sif();

    sync_fifo #(.W(34), .AW(DAW)) u_data_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .f(dif.mem)
    );

    sync_fifo #(.W(32), .AW(SAW)) u_status_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .f(sif.mem)
    );

    logic acc_done;
    logic wr_done;
    logic rd_done;
    logic hit;
    logic [31:0] rd_val;
    logic [31:0] info;
    logic [1:0] cfg;
    logic discard;
    logic half;
    logic [15:0] lo_half;
    logic word_v;
    logic [31:0] word;
    parse_t pst;
    logic last_seg;
    logic [10:0] idx;
    logic [2:0] first_dw;
    logic [9:0] keep;
    logic [10:0] total;
    logic [4:0] off;
    logic [10:0] size;
    logic [1:0] al;
    logic [11:0] span;
    logic [9:0] keep_c;
    logic [12:0] endb;
    logic [12:0] mask;
    logic [12:0] rounded;
    logic [10:0] total_c;
    logic [10:0] keep_lo;
    logic [10:0] keep_hi;
    logic in_keep;
    kind_t dkind;
    logic want_push;
    logic data_ovf;
    kind_t hkind;
    logic is_cmd;
    logic stall;
    logic load_out;
    logic [15:0] pkt_tag;
    logic [11:0] space;
    logic [31:0] sword;
    logic ovr;
    logic txe_set;
    logic [SAW:0] used;
    logic st_live;

    // one wait state: pready rises in the second access cycle
    assign acc_done = psel && penable && pready;
    assign wr_done = acc_done && pwrite;
    assign rd_done = acc_done && !pwrite;
    assign discard = cfg[`CFG_DISCARD];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_comb begin
        unique case (paddr)
            `OFF_DATA, `OFF_STATUS, `OFF_CFG, `OFF_INFO, `OFF_ERR, `OFF_SPACE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        info = '0;
        info[SAW:0] = used;
        info[`INFO_DCNT_LO +: DAW+1] = dif.count;
        info[`INFO_SUSP] = tx_suspended;
        info[`INFO_OVR] = ovr;
    end

    always_comb begin
        unique case (paddr)
            `OFF_STATUS: rd_val = sif.empty ? 32'h00000000 : sif.rdata;
            `OFF_CFG: rd_val = {30'h0, cfg};
            `OFF_INFO: rd_val = info;
            `OFF_ERR: rd_val = {31'h0, transmitter_error_flag};
            `OFF_SPACE: rd_val = {20'h00000, space};
            default: rd_val = 32'h00000000;
        endcase
    end

    // data is captured while pready is low so it stands for the ready cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            st_live <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h00000000 : rd_val;
            pslverr <= !hit;
            // pop only what was handed out; a push in the wait cycle must not be lost
            st_live <= !pwrite && paddr == `OFF_STATUS && !sif.empty;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `CFG_RESET;
        end else if (wr_done && paddr == `OFF_CFG) begin
            cfg <= pwdata[1:0];
        end
    end

    // host halves: low half is held, high half completes the word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half <= 1'b0;
            lo_half <= 16'h0000;
        end else if (wr_done && paddr == `OFF_DATA) begin
            half <= !half;
            if (!half) begin
                lo_half <= pwdata[15:0];
            end
        end
    end

    assign word_v = wr_done && paddr == `OFF_DATA && half;
    assign word = {pwdata[15:0], lo_half};

    // buffer geometry from the first command word
    assign off = word[`A_OFF_HI:`A_OFF_LO];
    assign size = word[`A_SIZE_HI:0];
    assign al = word[`A_ALIGN_HI:`A_ALIGN_LO];
    assign span = 12'(off[1:0]) + 12'(size);
    assign keep_c = 10'((span + 12'h003) >> 2);
    assign endb = 13'(off) + 13'(size);
    assign mask = (al == 2'h0) ? 13'h0003 : (al == 2'h1) ? 13'h000F : 13'h001F;
    assign rounded = (endb + mask) & ~mask;
    assign total_c = 11'(rounded >> 2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst <= WAIT_A;
            last_seg <= 1'b0;
            idx <= 11'h000;
            first_dw <= 3'h0;
            keep <= 10'h000;
            total <= 11'h000;
        end else if (word_v) begin
            unique case (pst)
                WAIT_A: begin
                    last_seg <= word[`A_LS];
                    first_dw <= off[4:2];
                    keep <= keep_c;
                    total <= total_c;
                    idx <= 11'h000;
                    pst <= word[`A_FS] ? WAIT_B : DATA_W;
                end
                WAIT_B: begin
                    pst <= DATA_W;
                end
                DATA_W: begin
                    idx <= idx + 11'h001;
                    if (idx == total - 11'h001) begin
                        pst <= WAIT_A;
                    end
                end
            endcase
        end
    end

    // only dwords that hold payload bytes are kept
    assign keep_lo = {8'h00, first_dw};
    assign keep_hi = keep_lo + {1'b0, keep};
    assign in_keep = idx >= keep_lo && idx < keep_hi;

    always_comb begin
        unique case (pst)
            WAIT_A: dkind = K_CMDA;
            WAIT_B: dkind = K_CMDB;
            DATA_W: dkind = (last_seg && idx == keep_hi - 11'h001) ? K_LAST : K_DATA;
            default: dkind = K_DATA;
        endcase
    end

    assign want_push = word_v && (pst != DATA_W || in_keep);
    assign dif.push = want_push && !dif.full;
    assign dif.wdata = {dkind, word};
    // a host overrun drops the word and is reported, it never stalls the bus
    assign data_ovf = want_push && dif.full;

    // drain toward the mac; commands leave the fifo but never the block
    assign hkind = kind_t'(dif.rdata[33:32]);
    assign is_cmd = hkind == K_CMDA || hkind == K_CMDB;
    assign stall = !dif.empty && hkind == K_CMDA && dif.rdata[`A_FS] && sif.full && !discard;
    assign dif.pop = !dif.empty && !stall && (is_cmd || !mac_valid || mac_ready);
    assign load_out = dif.pop && !is_cmd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_valid <= 1'b0;
            mac_data <= 32'h00000000;
            mac_last <= 1'b0;
        end else if (load_out) begin
            mac_valid <= 1'b1;
            mac_data <= dif.rdata[31:0];
            mac_last <= hkind == K_LAST;
        end else if (mac_ready) begin
            mac_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_tag <= 16'h0000;
        end else if (dif.pop && hkind == K_CMDB) begin
            pkt_tag <= dif.rdata[`B_TAG_HI:`B_TAG_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            space <= 12'h000;
        end else if (dif.pop && hkind == K_CMDA && dif.rdata[`A_FS]) begin
            space <= 12'h000;
        end else if (load_out) begin
            space <= space + `DW_BYTES;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_suspended <= 1'b0;
        end else begin
            tx_suspended <= stall;
        end
    end

    tx_status_word u_status_word (
        .res(mac_result),
        .tag(pkt_tag),
        .defer_check(cfg[`CFG_DEFER]),
        .word(sword)
    );

    assign sif.push = mac_tx_done && !sif.full && !ovr;
    assign sif.wdata = sword;
    assign sif.pop = rd_done && paddr == `OFF_STATUS && st_live && !sif.empty;
    assign used = ovr ? '0 : sif.count;

    // overrun ends with the next status read; a new overrun in that cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr <= 1'b0;
        end else if (mac_tx_done && sif.full && discard) begin
            ovr <= 1'b1;
        end else if (sif.pop) begin
            ovr <= 1'b0;
        end
    end

    assign txe_set = data_ovf || (mac_tx_done && sif.full && !discard);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmitter_error_flag <= 1'b0;
        end else if (txe_set) begin
            transmitter_error_flag <= 1'b1;
        end else if (wr_done && paddr == `OFF_ERR && pwdata[`ERR_TXE]) begin
            transmitter_error_flag <= 1'b0;
        end
    end

    sequence s_low_half;
        wr_done && paddr == `OFF_DATA && !half;
    endsequence

    sequence s_high_half;
        wr_done && paddr == `OFF_DATA;
    endsequence

    property p_pair;
        @(posedge pclk) disable iff (!presetn)
        s_low_half |-> !word_v ##1 half;
    endproperty
    a_pair: assert property (p_pair) else $error("low half did not wait for its partner");

    property p_word;
        @(posedge pclk) disable iff (!presetn)
        s_high_half |-> (word_v == half) ##1 (half == !$past(half));
    endproperty
    a_word: assert property (p_word) else $error("host halves out of step");

    property p_es;
        @(posedge pclk) disable iff (!presetn)
        sif.push |-> sif.wdata[`ST_ES] == |{sif.wdata[11:8], sif.wdata[2:1]};
    endproperty
    a_es: assert property (p_es) else $error("error summary mismatch");

    property p_rsvd;
        @(posedge pclk) disable iff (!presetn)
        sif.push |-> sif.wdata[14:12] == 3'h0 && !sif.wdata[7] && !sif.wdata[1];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");

    property p_tag;
        @(posedge pclk) disable iff (!presetn)
        (dif.pop && hkind == K_CMDB) |=> pkt_tag == $past(dif.rdata[31:16]);
    endproperty
    a_tag: assert property (p_tag) else $error("status tag differs from command");

    property p_one_status;
        @(posedge pclk) disable iff (!presetn)
        (mac_tx_done && !sif.full && !ovr && !sif.pop) |=> sif.count == $past(sif.count) + (SAW+1)'(1);
    endproperty
    a_one_status: assert property (p_one_status) else $error("status word not stored");

    property p_suspend;
        @(posedge pclk) disable iff (!presetn)
        stall |-> !dif.pop ##1 tx_suspended;
    endproperty
    a_suspend: assert property (p_suspend) else $error("packet started with full status fifo");

    property p_no_txe_discard;
        @(posedge pclk) disable iff (!presetn)
        (mac_tx_done && sif.full && discard && !data_ovf && !transmitter_error_flag) |=> !transmitter_error_flag;
    endproperty
    a_no_txe_discard: assert property (p_no_txe_discard) else $error("error raised in discard mode");

    property p_txe_overrun;
        @(posedge pclk) disable iff (!presetn)
        (mac_tx_done && sif.full && !discard) |=> transmitter_error_flag;
    endproperty
    a_txe_overrun: assert property (p_txe_overrun) else $error("overrun did not raise error");

    property p_ovr_hold;
        @(posedge pclk) disable iff (!presetn)
        (ovr && !sif.pop) |=> ovr && !sif.push && used == '0;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("status stored during overrun");

    property p_strip;
        @(posedge pclk) disable iff (!presetn)
        (dif.pop && is_cmd) |=> $stable(mac_data) && !$rose(mac_valid);
    endproperty
    a_strip: assert property (p_strip) else $error("command word reached mac");

    property p_cmdb;
        @(posedge pclk) disable iff (!presetn)
        (word_v && pst == WAIT_A && !word[`A_FS]) |=> pst == DATA_W;
    endproperty
    a_cmdb: assert property (p_cmdb) else $error("second command expected without first segment");

    property p_defer;
        @(posedge pclk) disable iff (!presetn)
        (sif.push && !cfg[`CFG_DEFER]) |-> !sif.wdata[`ST_EDEF];
    endproperty
    a_defer: assert property (p_defer) else $error("deferral bit without checking");
endmodule

/* verilog/tx_cfg.svh */
`ifndef TX_CFG_SVH
`define TX_CFG_SVH

// register byte offsets
`define OFF_DATA 8'h00
`define OFF_STATUS 8'h04
`define OFF_CFG 8'h08
`define OFF_INFO 8'h0C
`define OFF_ERR 8'h10
`define OFF_SPACE 8'h14

// config, error and info fields
`define CFG_DISCARD 0
`define CFG_DEFER 1
`define CFG_RESET 2'h0
`define ERR_TXE 0
`define INFO_DCNT_LO 8
`define INFO_SUSP 28
`define INFO_OVR 29

// first command word fields
`define A_FS 13
`define A_LS 12
`define A_SIZE_HI 10
`define A_OFF_HI 20
`define A_OFF_LO 16
`define A_ALIGN_HI 25
`define A_ALIGN_LO 24

// second command word fields
`define B_TAG_HI 31
`define B_TAG_LO 16

// status word fields
`define ST_TAG_HI 31
`define ST_TAG_LO 16
`define ST_ES 15
`define ST_LOC 11
`define ST_NOC 10
`define ST_LATE 9
`define ST_EXC 8
`define ST_CC_HI 6
`define ST_CC_LO 3
`define ST_EDEF 2
`define ST_DEF 0

// bytes charged per kept dword in the mac-side store
`define DW_BYTES 12'h004

`endif

/* verilog/tx_pkg.sv */
package tx_pkg;

    typedef enum logic [1:0] {
        WAIT_A = 2'b00,
        WAIT_B = 2'b01,
        DATA_W = 2'b11
    } parse_t;

    typedef enum logic [1:0] {
        K_DATA = 2'b00,
        K_CMDA = 2'b01,
        K_CMDB = 2'b10,
        K_LAST = 2'b11
    } kind_t;

    typedef struct packed {
        logic lost_carrier;
        logic no_carrier;
        logic late_col;
        logic excess_col;
        logic [3:0] col_count;
        logic excess_defer;
        logic deferred;
    } tx_result_t;

endpackage

/* verilog/fifo_if.sv */
interface fifo_if #(
    parameter int W = 32,
    parameter int AW = 4
);
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [AW:0] count;

    modport mem(input push, pop, wdata, output full, empty, rdata, count);
    modport user(output push, pop, wdata, input full, empty, rdata, count);
endinterface

/* verilog/sync_fifo.sv */
module sync_fifo #(
    parameter int W = 32,
    parameter int AW = 4
) (
    input logic pclk,     // system clock
    input logic presetn,  // async reset, active low
    fifo_if.mem f         // push/pop side
);
    logic [W-1:0] mem [2**AW];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;

    // first word falls through, so the head is readable without a pop
    assign f.rdata = mem[rp];
    assign f.count = cnt;
    assign f.empty = (cnt == '0);
    assign f.full = (cnt == (AW+1)'(2**AW));

    always_ff @(posedge pclk) begin
        if (f.push && !f.full) begin
            mem[wp] <= f.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (f.push && !f.full) begin
                wp <= wp + AW'(1);
            end
            if (f.pop && !f.empty) begin
                rp <= rp + AW'(1);
            end
            cnt <= cnt + (AW+1)'(f.push && !f.full) - (AW+1)'(f.pop && !f.empty);
        end
    end
endmodule

/* verilog/tx_status_word.sv */
`include "tx_cfg.svh"
module tx_status_word import tx_pkg::*; (
    input tx_result_t res,     // outcome of the finished packet
    input logic [15:0] tag,    // tag from the packet's second command
    input logic defer_check,   // deferral checking enabled
    output logic [31:0] word   // packed status word
);
    always_comb begin
        word = '0;
        word[`ST_TAG_HI:`ST_TAG_LO] = tag;
        word[`ST_LOC] = res.lost_carrier;
        word[`ST_NOC] = res.no_carrier;
        word[`ST_LATE] = res.late_col;
        word[`ST_EXC] = res.excess_col;
        word[`ST_CC_HI:`ST_CC_LO] = res.col_count;
        word[`ST_EDEF] = res.excess_defer && defer_check;
        word[`ST_DEF] = res.deferred;
        // reserved bits stay at the zero given above
        word[`ST_ES] = |{word[11:8], word[2:1]};
    end
endmodule

/* dv/mac_model.sv */
module mac_model import tx_pkg::*; (
    input wire logic pclk,             // system clock
    input wire logic presetn,          // async reset, active low
    input wire logic mac_valid,        // word on offer
    input wire logic [31:0] mac_data,  // offered word
    input wire logic mac_last,         // last word of packet
    output logic mac_ready,            // take strobe, stalls every other cycle
    output logic mac_tx_done,          // packet finished pulse
    output tx_result_t mac_result,     // outcome with done
    input wire tx_result_t res,        // outcome chosen by the bench
    input wire logic kick,             // spurious done request
    output logic [7:0] cnt,            // words taken
    output logic [31:0] last_w         // last word taken
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] dly;
    logic ph;
    // outside done the result is inverted so stale values cannot pass
    assign mac_result = mac_tx_done ? res : ~res;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 1'b0;
            mac_ready <= 1'b0;
            mac_tx_done <= 1'b0;
            cnt <= 8'h00;
            last_w <= 32'h0000_0000;
            dly <= 3'h0;
        end else begin
            ph <= ~ph;
            mac_ready <= ph;
            mac_tx_done <= kick;
            if (dly != 3'h0) begin
                dly <= dly - 3'h1;
                if (dly == 3'h1) begin
                    mac_tx_done <= 1'b1;
                end
            end
            if (mac_valid && mac_ready) begin
                cnt <= cnt + 8'h01;
                last_w <= mac_data;
                if (mac_last) begin
                    dly <= 3'h3;
                end
            end
        end
    end
endmodule

/* dv/tx_fifo_packing_and_status_test.sv */
`include "tx_cfg.svh"
module tx_fifo_packing_and_status_test import tx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0, err;
    logic [7:0] paddr = 8'h00, cnt;
    logic [31:0] pwdata = 32'h0000_0000, prdata, mac_data, rd, last_w;
    logic pready, pslverr, mac_ready, mac_valid, mac_last, mac_tx_done, tx_suspended, transmitter_error_flag;
    tx_result_t mac_result, res = '0;
    tx_result_t tab [5];
    int miscompares = 0, cmp_count = 0;
    always #50 pclk = ~pclk;
    tx_fifo_packing_and_status #(.DAW(6), .SAW(1)) tx_fifo_packing_and_status_inst (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_ready(mac_ready), .mac_valid(mac_valid),
        .mac_data(mac_data), .mac_last(mac_last), .mac_tx_done(mac_tx_done), .mac_result(mac_result),
        .tx_suspended(tx_suspended), .transmitter_error_flag(transmitter_error_flag));
    mac_model mac_model_inst (.pclk(pclk), .presetn(presetn), .mac_valid(mac_valid), .mac_data(mac_data),
        .mac_last(mac_last), .mac_ready(mac_ready), .mac_tx_done(mac_tx_done), .mac_result(mac_result),
        .res(res), .kick(kick), .cnt(cnt), .last_w(last_w));
    function automatic logic [31:0] st(input logic [15:0] t, input tx_result_t r, input logic dc);
        logic e;
        e = r.excess_defer & dc;
        return {t, r.lost_carrier | r.no_carrier | r.late_col | r.excess_col | e, 3'h0, r.lost_carrier,
            r.no_carrier, r.late_col, r.excess_col, 1'b0, r.col_count, e, 1'b0, r.deferred};
    endfunction
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            $display("BAD pready expected 1 seen %b", pready);
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        cmp(nm, exp, rd);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input string nm);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
        end while ((rd & m) !== v && n < 200);
        cmp(nm, v, rd & m);
    endtask
    task automatic wait_cnt(input logic [7:0] n);
        int k;
        k = 0;
        while (cnt !== n && k < 200) begin
            @(posedge pclk);
            k++;
        end
        cmp("mac words", {24'h0, n}, {24'h0, cnt});
    endtask
    task automatic wr32(input logic [31:0] w);
        apb(1'b1, `OFF_DATA, {16'h0000, w[15:0]});
        apb(1'b1, `OFF_DATA, {16'h0000, w[31:16]});
    endtask
    // one small buffer per packet: offset 5, 3 bytes, 4-byte end alignment
    task automatic send(input logic [15:0] tag, input logic [31:0] d);
        wr32(32'h0005_3003);
        wr32({tag, 16'h0000});
        wr32(~d);
        wr32(d);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        tab[0] = 10'h218;
        tab[1] = 10'h103;
        tab[2] = 10'h080;
        tab[3] = 10'h07C;
        tab[4] = 10'h002;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`OFF_CFG, 32'h0, "cfg reset");
        rdc(`OFF_INFO, 32'h0, "info reset");
        rdc(`OFF_ERR, 32'h0, "err reset");
        apb(1'b0, 8'h20, 32'h0);
        cmp("unmapped err", 32'h1, {31'h0, err});
        cmp("unmapped data", 32'h0, rd);
        for (int i = 0; i < 5; i++) begin
            res <= tab[i];
            apb(1'b1, `OFF_CFG, (i < 4) ? 32'h2 : 32'h0);
            send(16'hA500 + 16'(i), 32'h1234_5670 + 32'(i));
            wait_cnt(8'(i + 1));
            cmp("mac word", 32'h1234_5670 + 32'(i), last_w);
            rdc(`OFF_SPACE, 32'h4, "space");
            poll(`OFF_INFO, 32'h3, 32'h1, "used one");
            rdc(`OFF_STATUS, st(16'hA500 + 16'(i), tab[i], i < 4), "status");
            rdc(`OFF_INFO, 32'h0, "used empty");
        end
        res <= '0;
        apb(1'b1, `OFF_CFG, 32'h0);
        send(16'hB000, 32'h1);
        send(16'hB001, 32'h2);
        wait_cnt(8'd7);
        poll(`OFF_INFO, 32'h3, 32'h2, "used full");
        send(16'hB002, 32'h3);
        poll(`OFF_INFO, 32'h1000_0000, 32'h1000_0000, "suspended info");
        cmp("suspended", 32'h1, {31'h0, tx_suspended});
        cmp("held words", 32'h7, {24'h0, cnt});
        rdc(`OFF_STATUS, st(16'hB000, '0, 1'b0), "status b0");
        wait_cnt(8'd8);
        poll(`OFF_INFO, 32'h3, 32'h2, "used refill");
        rdc(`OFF_STATUS, st(16'hB001, '0, 1'b0), "status b1");
        rdc(`OFF_STATUS, st(16'hB002, '0, 1'b0), "status b2");
        apb(1'b1, `OFF_CFG, 32'h1);
        send(16'hC000, 32'h4);
        send(16'hC001, 32'h5);
        wait_cnt(8'd10);
        poll(`OFF_INFO, 32'h3, 32'h2, "used full");
        send(16'hC002, 32'h6);
        wait_cnt(8'd11);
        poll(`OFF_INFO, 32'h2000_0003, 32'h2000_0000, "overrun");
        rdc(`OFF_ERR, 32'h0, "no error");
        rdc(`OFF_STATUS, st(16'hC000, '0, 1'b0), "kept status");
        send(16'hC003, 32'h7);
        wait_cnt(8'd12);
        poll(`OFF_INFO, 32'h3, 32'h2, "used after free");
        rdc(`OFF_STATUS, st(16'hC001, '0, 1'b0), "status c1");
        rdc(`OFF_STATUS, st(16'hC003, '0, 1'b0), "status c3");
        apb(1'b1, `OFF_CFG, 32'h0);
        send(16'hD000, 32'h8);
        send(16'hD001, 32'h9);
        wait_cnt(8'd14);
        poll(`OFF_INFO, 32'h3, 32'h2, "used full");
        @(posedge pclk);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        poll(`OFF_ERR, 32'h1, 32'h1, "error set");
        cmp("error pin", 32'h1, {31'h0, transmitter_error_flag});
        apb(1'b1, `OFF_ERR, 32'h1);
        rdc(`OFF_ERR, 32'h0, "error cleared");
        rdc(`OFF_STATUS, st(16'hD000, '0, 1'b0), "status d0");
        rdc(`OFF_STATUS, st(16'hD001, '0, 1'b0), "status d1");
        tally_and_finish();
    end
endmodule
